//--- hw/reset_cause_flags.sv
// reset cause flag register with axi4-lite slave and interrupt
// assumes event inputs are one-cycle pulses synchronous to aclk
//
// Summary of operation
// - stack overflow sets bit 7; held until firmware writes 0
// - stack underflow sets bit 6; held until firmware writes 0
// - bit 5 reads zero and ignores writes
// - watchdog reset clears bit 4; firmware may write 1
// - external pin reset clears bit 3; firmware may write 1
// - reset instruction clears bit 2; firmware may write 1
// - power-on clears bit 1; firmware rewrites 1 to re-arm
// - brown-out clears bit 0; firmware rewrites 1 to re-arm
// - power-on/brown-out load stacks 0, watchdog/pin/instruction 1
// - low-power brown-out monitor ORed with main brown-out
// - stack events set stack flags only when stack fault reset enabled
`timescale 1ns/1ns
`default_nettype none
`include "reset_cause_defines.svh"
module reset_cause_flags
	import reset_cause_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        stack_over,
	input  wire logic        stack_under,
	input  wire logic        watchdog_reset,
	input  wire logic        external_reset_pin,
	input  wire logic        reset_instr,
	input  wire logic        power_on_reset,
	input  wire logic        brownout_reset,
	input  wire logic        low_power_brownout_monitor,
	output logic             irq
);
	cause_t     flags_ff;
	cause_t     nxt_flags;
	logic       enable_ff;
	logic       nxt_enable;
	cause_t     stat_ff;
	cause_t     nxt_stat;
	cause_t     mask_ff;
	cause_t     nxt_mask;
	logic       irq_ff;
	logic       nxt_irq;
	logic       aw_ff;
	logic       nxt_aw;
	logic       w_ff;
	logic       nxt_w;
	logic [3:0] awaddr_ff;
	logic [3:0] nxt_awaddr;
	logic [31:0] wdata_ff;
	logic [31:0] nxt_wdata;
	logic [3:0] wstrb_ff;
	logic [3:0] nxt_wstrb;
	logic       bvalid_ff;
	logic       nxt_bvalid;
	logic [1:0] bresp_ff;
	logic [1:0] nxt_bresp;
	logic       rvalid_ff;
	logic       nxt_rvalid;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [1:0] rresp_ff;
	logic [1:0] nxt_rresp;
	logic       awready_ff;
	logic       nxt_awready;
	logic       wready_ff;
	logic       nxt_wready;
	logic       arready_ff;
	logic       nxt_arready;
	logic       brownout_event;
	logic       ovf_event;
	logic       unf_event;
	power_ev_t  power_ev;
	logic       do_write;
	logic       cause_wr;
	cause_t     ev_bits;

	reset_event_merge u_merge (
		.stack_over                 (stack_over),
		.stack_under                (stack_under),
		.stack_fault_reset_enable   (enable_ff),
		.brownout_main              (brownout_reset),
		.low_power_brownout_monitor (low_power_brownout_monitor),
		.por_event                  (power_on_reset),
		.brownout_event             (brownout_event),
		.ovf_event                  (ovf_event),
		.unf_event                  (unf_event),
		.power_ev                   (power_ev)
	);

	assign do_write = aw_ff & w_ff & ~bvalid_ff;
	assign cause_wr = do_write & (awaddr_ff == `RC_OFF_CAUSE) & wstrb_ff[0];

	cause_flag_update u_update (
		.cur         (flags_ff),
		.wr_en       (cause_wr),
		.wr_data     (wdata_ff[7:0]),
		.power_ev    (power_ev),
		.ovf_event   (ovf_event),
		.unf_event   (unf_event),
		.wdt_event   (watchdog_reset),
		.pin_event   (external_reset_pin),
		.instr_event (reset_instr),
		.nxt         (nxt_flags)
	);

	// bus write path and register updates
	always_comb
	begin
		nxt_aw     = aw_ff;
		nxt_w      = w_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata  = wdata_ff;
		nxt_wstrb  = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp  = bresp_ff;
		nxt_enable = enable_ff;
		nxt_mask   = mask_ff;
		nxt_stat   = stat_ff;
		if (s_axi_awvalid && !aw_ff)
		begin
			nxt_aw     = 1'b1;
			nxt_awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_ff)
		begin
			nxt_w     = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		if (bvalid_ff && s_axi_bready)
			nxt_bvalid = 1'b0;
		if (do_write)
		begin
			nxt_aw     = 1'b0;
			nxt_w      = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp  = `AXI_RESP_OKAY;
			case (awaddr_ff)
				`RC_OFF_CAUSE:
				begin
				end
				`RC_OFF_CTRL:
				begin
					if (wstrb_ff[0])
						nxt_enable = wdata_ff[0];
				end
				`RC_OFF_IRQ_STAT:
				begin
					if (wstrb_ff[0])
						nxt_stat = stat_ff & ~wdata_ff[7:0];
				end
				`RC_OFF_IRQ_MASK:
				begin
					if (wstrb_ff[0])
						nxt_mask = wdata_ff[7:0] & `RC_IMPL_MASK;
				end
				default:
					nxt_bresp = `AXI_RESP_SLVERR;
			endcase
		end
		// events set status after clear, so set wins
		nxt_stat = nxt_stat | ev_bits;
		nxt_irq  = |(nxt_stat & nxt_mask);
		nxt_awready = ~nxt_aw;
		nxt_wready  = ~nxt_w;
	end

	always_comb
	begin
		ev_bits = 8'h00;
		ev_bits[`RC_BIT_STK_OVER]  = ovf_event;
		ev_bits[`RC_BIT_STK_UNDER] = unf_event;
		ev_bits[`RC_BIT_WDT]       = watchdog_reset;
		ev_bits[`RC_BIT_PIN]       = external_reset_pin;
		ev_bits[`RC_BIT_INSTR]     = reset_instr;
		ev_bits[`RC_BIT_POR]       = power_on_reset;
		ev_bits[`RC_BIT_BROWNOUT]  = brownout_event;
	end

	// bus read path
	always_comb
	begin
		nxt_rvalid = rvalid_ff;
		nxt_rdata  = rdata_ff;
		nxt_rresp  = rresp_ff;
		if (rvalid_ff && s_axi_rready)
			nxt_rvalid = 1'b0;
		if (s_axi_arvalid && !rvalid_ff)
		begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = `AXI_RESP_OKAY;
			nxt_rdata  = 32'h0000_0000;
			case (s_axi_araddr)
				`RC_OFF_CAUSE:
					nxt_rdata[7:0] = flags_ff;
				`RC_OFF_CTRL:
					nxt_rdata[0] = enable_ff;
				`RC_OFF_IRQ_STAT:
					nxt_rdata[7:0] = stat_ff;
				`RC_OFF_IRQ_MASK:
					nxt_rdata[7:0] = mask_ff;
				default:
					nxt_rresp = `AXI_RESP_SLVERR;
			endcase
		end
		nxt_arready = ~nxt_rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			flags_ff  <= `RC_POR_VALUE;
			enable_ff <= `RC_CTRL_RESET;
			stat_ff   <= 8'h00;
			mask_ff   <= 8'h00;
			irq_ff    <= 1'b0;
			aw_ff     <= 1'b0;
			w_ff      <= 1'b0;
			awaddr_ff <= 4'h0;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= 2'b00;
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= 2'b00;
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			arready_ff <= 1'b1;
		end
		else
		begin
			flags_ff  <= nxt_flags;
			enable_ff <= nxt_enable;
			stat_ff   <= nxt_stat;
			mask_ff   <= nxt_mask;
			irq_ff    <= nxt_irq;
			aw_ff     <= nxt_aw;
			w_ff      <= nxt_w;
			awaddr_ff <= nxt_awaddr;
			wdata_ff  <= nxt_wdata;
			wstrb_ff  <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff  <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff  <= nxt_rdata;
			rresp_ff  <= nxt_rresp;
			awready_ff <= nxt_awready;
			wready_ff  <= nxt_wready;
			arready_ff <= nxt_arready;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign irq           = irq_ff;

	a_ovf_sets: assert property (@(posedge aclk) disable iff (!aresetn)
		ovf_event && power_ev == EV_NONE |=> flags_ff[`RC_BIT_STK_OVER])
		else $error("overflow flag not set");
	a_unf_sets: assert property (@(posedge aclk) disable iff (!aresetn)
		unf_event && power_ev == EV_NONE |=> flags_ff[`RC_BIT_STK_UNDER])
		else $error("underflow flag not set");
	a_bit5_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 !flags_ff[`RC_BIT_UNIMP])
		else $error("bit 5 not zero");
	a_wdt_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		watchdog_reset && power_ev == EV_NONE |=> !flags_ff[`RC_BIT_WDT])
		else $error("watchdog flag not cleared");
	a_pin_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		external_reset_pin && power_ev == EV_NONE |=> !flags_ff[`RC_BIT_PIN])
		else $error("pin flag not cleared");
	a_instr_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		reset_instr && power_ev == EV_NONE |=> !flags_ff[`RC_BIT_INSTR])
		else $error("instruction flag not cleared");
	a_por_load: assert property (@(posedge aclk) disable iff (!aresetn)
		power_on_reset |=> flags_ff[7:1] == 7'h0e)
		else $error("power-on load wrong");
	a_brownout_load: assert property (@(posedge aclk) disable iff (!aresetn)
		(brownout_reset || low_power_brownout_monitor) && !power_on_reset
		|=> !flags_ff[`RC_BIT_BROWNOUT] && flags_ff[7:2] == 6'h07)
		else $error("brown-out load wrong");
	a_stack_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		!enable_ff && !cause_wr && power_ev == EV_NONE
		|=> flags_ff[7:6] == $past(flags_ff[7:6]))
		else $error("stack flag changed while disabled");
	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		irq == |(stat_ff & mask_ff))
		else $error("irq mismatch");
endmodule
`default_nettype wire

//--- hw/reset_cause_defines.svh
// reset cause block constants: offsets, bit positions, reset values
// assumes inclusion by bare name from hw/ files
`ifndef RESET_CAUSE_DEFINES_SVH
`define RESET_CAUSE_DEFINES_SVH

`define RC_ADDR_W        4
`define RC_OFF_CAUSE     4'h0
`define RC_OFF_CTRL      4'h4
`define RC_OFF_IRQ_STAT  4'h8
`define RC_OFF_IRQ_MASK  4'hc

`define RC_BIT_STK_OVER  7
`define RC_BIT_STK_UNDER 6
`define RC_BIT_UNIMP     5
`define RC_BIT_WDT       4
`define RC_BIT_PIN       3
`define RC_BIT_INSTR     2
`define RC_BIT_POR       1
`define RC_BIT_BROWNOUT  0

`define RC_IMPL_MASK     8'hdf
`define RC_POR_VALUE     8'h1c
`define RC_BROWNOUT_LOAD 8'h1c
`define RC_CTRL_RESET    1'b1

`define AXI_RESP_OKAY    2'b00
`define AXI_RESP_SLVERR  2'b10

`endif

//--- hw/reset_cause_pkg.sv
// reset cause block types
// assumes nothing beyond the defines header
package reset_cause_pkg;
	typedef logic [7:0] cause_t;
	typedef enum logic [2:0] {
		EV_NONE,
		EV_POR,
		EV_BROWNOUT,
		EV_OTHER
	} power_ev_t;
endpackage

//--- hw/reset_event_merge.sv
// merges raw reset requests into per-flag event pulses
// assumes all event inputs are single-cycle pulses on aclk
`timescale 1ns/1ns
`default_nettype none
`include "reset_cause_defines.svh"
module reset_event_merge
	import reset_cause_pkg::*;
(
	input  wire logic                    stack_over,
	input  wire logic                    stack_under,
	input  wire logic                    stack_fault_reset_enable,
	input  wire logic                    brownout_main,
	input  wire logic                    low_power_brownout_monitor,
	input  wire logic                    por_event,
	output logic                         brownout_event,
	output logic                         ovf_event,
	output logic                         unf_event,
	output reset_cause_pkg::power_ev_t   power_ev
);
	always_comb
	begin
		brownout_event = brownout_main | low_power_brownout_monitor;
		ovf_event = stack_over & stack_fault_reset_enable;
		unf_event = stack_under & stack_fault_reset_enable;
		if (por_event)
			power_ev = EV_POR;
		else if (brownout_event)
			power_ev = EV_BROWNOUT;
		else
			power_ev = EV_NONE;
	end
endmodule
`default_nettype wire

//--- hw/cause_flag_update.sv
// computes next flag byte from events and firmware write
// assumes one-cycle event pulses
`timescale 1ns/1ns
`default_nettype none
`include "reset_cause_defines.svh"
module cause_flag_update
	import reset_cause_pkg::*;
(
	input  wire reset_cause_pkg::cause_t cur,
	input  wire logic                    wr_en,
	input  wire reset_cause_pkg::cause_t wr_data,
	input  wire reset_cause_pkg::power_ev_t power_ev,
	input  wire logic                    ovf_event,
	input  wire logic                    unf_event,
	input  wire logic                    wdt_event,
	input  wire logic                    pin_event,
	input  wire logic                    instr_event,
	output reset_cause_pkg::cause_t      nxt
);
	always_comb
	begin
		nxt = cur;
		if (wr_en)
			nxt = wr_data & `RC_IMPL_MASK;
		if (power_ev == EV_POR)
		begin
			nxt = `RC_POR_VALUE;
			nxt[`RC_BIT_BROWNOUT] = cur[`RC_BIT_BROWNOUT];
			nxt[`RC_BIT_POR] = 1'b0;
		end
		else if (power_ev == EV_BROWNOUT)
		begin
			nxt = `RC_BROWNOUT_LOAD;
			nxt[`RC_BIT_POR] = cur[`RC_BIT_POR];
			nxt[`RC_BIT_BROWNOUT] = 1'b0;
		end
		else
		begin
			// hardware events win over the write
			if (ovf_event)
				nxt[`RC_BIT_STK_OVER] = 1'b1;
			if (unf_event)
				nxt[`RC_BIT_STK_UNDER] = 1'b1;
			if (wdt_event)
				nxt[`RC_BIT_WDT] = 1'b0;
			if (pin_event)
				nxt[`RC_BIT_PIN] = 1'b0;
			if (instr_event)
				nxt[`RC_BIT_INSTR] = 1'b0;
		end
		nxt[`RC_BIT_UNIMP] = 1'b0;
	end
endmodule
`default_nettype wire

//--- tb/reset_cause_flags_test.sv
// self-checking bench for the reset cause flag block
// assumes reset_cause_defines.svh on the include path
`timescale 1ns/1ns
`default_nettype none
`include "reset_cause_defines.svh"
module reset_cause_flags_test;
	import reset_cause_pkg::*;
	logic         aclk = 1'b0;
	logic         aresetn = 1'b0;
	logic [3:0]   awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
	logic [31:0]  wdata = 32'h0, rdata;
	logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic         awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]   bresp, rresp;
	logic [7:0]   evt = 8'h00;
	logic [33:0]  rq[$];
	logic [1:0]   bq[$];
	logic [33:0]  re;
	logic [7:0]   st[8], ex[8];
	int           bp[8];
	int           n_fail = 0, n_tests = 0, seed;
	logic [31:0]  d;

	always #20 aclk = ~aclk;

	reset_cause_flags dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .stack_over(evt[0]),
		.stack_under(evt[1]), .watchdog_reset(evt[2]), .external_reset_pin(evt[3]),
		.reset_instr(evt[4]), .power_on_reset(evt[5]), .brownout_reset(evt[6]),
		.low_power_brownout_monitor(evt[7]), .irq(irq));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("checks %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
		bq.push_back(r);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
		rq.push_back({r, v});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic pulse(input int i);
		evt <= 8'h01 << i;
		@(posedge aclk);
		evt <= 8'h00;
		@(posedge aclk);
	endtask

	// result watcher: oldest note against each answer
	always @(posedge aclk)
	begin
		if (rvalid && rready)
		begin
			re = rq.pop_front();
			chk("rresp", {30'h0, re[33:32]}, {30'h0, rresp});
			if (re[33:32] === `AXI_RESP_OKAY)
				chk("rdata", re[31:0], rdata);
		end
		if (bvalid && bready)
			chk("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
	end

	initial
	begin
		repeat (6000) @(posedge aclk);
		n_fail++;
		conclude();
	end

	initial
	begin
		seed = 32'hc876;
		st = '{8'h1f, 8'h1f, 8'hdf, 8'hdf, 8'hdf, 8'hdf, 8'hdf, 8'hdf};
		ex = '{8'h9f, 8'h5f, 8'hcf, 8'hd7, 8'hdb, 8'h1d, 8'h1e, 8'h1e};
		bp = '{7, 6, 4, 3, 2, 1, 0, 0};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`RC_OFF_CAUSE, 32'h1c, `AXI_RESP_OKAY);
		rd(`RC_OFF_CTRL, 32'h1, `AXI_RESP_OKAY);
		rd(`RC_OFF_IRQ_STAT, 32'h0, `AXI_RESP_OKAY);
		rd(`RC_OFF_IRQ_MASK, 32'h0, `AXI_RESP_OKAY);
		wr(`RC_OFF_CAUSE, 32'hffffffff, `AXI_RESP_OKAY);
		rd(`RC_OFF_CAUSE, 32'hdf, `AXI_RESP_OKAY);
		wr(`RC_OFF_CAUSE, 32'h0, `AXI_RESP_OKAY);
		rd(`RC_OFF_CAUSE, 32'h0, `AXI_RESP_OKAY);
		// every event source from a known start value
		for (int i = 0; i < 8; i++)
		begin
			wr(`RC_OFF_IRQ_STAT, 32'hff, `AXI_RESP_OKAY);
			wr(`RC_OFF_CAUSE, {24'h0, st[i]}, `AXI_RESP_OKAY);
			pulse(i);
			rd(`RC_OFF_CAUSE, {24'h0, ex[i]}, `AXI_RESP_OKAY);
			rd(`RC_OFF_IRQ_STAT, 32'h1 << bp[i], `AXI_RESP_OKAY);
		end
		// stack faults disabled
		wr(`RC_OFF_CTRL, 32'h0, `AXI_RESP_OKAY);
		wr(`RC_OFF_CAUSE, 32'h1f, `AXI_RESP_OKAY);
		pulse(0);
		pulse(1);
		rd(`RC_OFF_CAUSE, 32'h1f, `AXI_RESP_OKAY);
		wr(`RC_OFF_CTRL, 32'h1, `AXI_RESP_OKAY);
		// watchdog event only in the cycle that applies the write
		fork
			wr(`RC_OFF_CAUSE, 32'h1f, `AXI_RESP_OKAY);
			begin
				do
					@(posedge aclk);
				while (!(awvalid && awready));
				evt <= 8'h04;
				@(posedge aclk);
				evt <= 8'h00;
			end
		join
		rd(`RC_OFF_CAUSE, 32'h0f, `AXI_RESP_OKAY);
		repeat (4)
		begin
			d = $random(seed);
			wr(`RC_OFF_CAUSE, d, `AXI_RESP_OKAY);
			repeat (3) @(posedge aclk);
			rd(`RC_OFF_CAUSE, {24'h0, d[7:0] & 8'hdf}, `AXI_RESP_OKAY);
		end
		// interrupt raise, mask, clear
		wr(`RC_OFF_IRQ_STAT, 32'hff, `AXI_RESP_OKAY);
		pulse(3);
		rd(`RC_OFF_IRQ_STAT, 32'h08, `AXI_RESP_OKAY);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`RC_OFF_IRQ_MASK, 32'h08, `AXI_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("irq", 32'h1, {31'h0, irq});
		wr(`RC_OFF_IRQ_STAT, 32'h08, `AXI_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("irq", 32'h0, {31'h0, irq});
		rd(`RC_OFF_IRQ_STAT, 32'h0, `AXI_RESP_OKAY);
		// unmapped offsets
		rd(4'h2, 32'h0, `AXI_RESP_SLVERR);
		wr(4'h6, 32'hff, `AXI_RESP_SLVERR);
		// lane 0 strobe off: cause write ignored
		wstrb <= 4'he;
		wr(`RC_OFF_CAUSE, 32'h0, `AXI_RESP_OKAY);
		wstrb <= 4'hf;
		rd(`RC_OFF_CAUSE, {24'h0, d[7:0] & 8'hd7}, `AXI_RESP_OKAY);
		repeat (4) @(posedge aclk);
		conclude();
	end
endmodule
`default_nettype wire
